// File: core/alarm_compare_map.vh
// Register offsets, field layouts and counts of the alarm compare block.
// Operation
// - Daily hour D5 is p.m. flag in 12-hour mode, tens-twenty bit in 24-hour.
// - Weekly hour D5 is p.m. flag in 12-hour mode, tens-twenty bit in 24-hour.
// - 12-hour hours: midnight is 12, noon is 32; compare raw encoding.
// - Enable bit n matches weekday counter value n, from 0 to 6.
// - All weekday enables zero: weekly alarm never matches.
// - Daily minute at Bh, seven bits, top bit reads zero.
// - Daily hour at Ch, six bits, two top bits read zero.
// - Weekday mask at Ah, seven bits, top bit reads zero.
// - Oscillator stop leaves alarm fields undefined; fixed-zero bits still read zero.
// - Weekly minute at 8h, seven bits, top bit reads zero.
// - Weekly hour at 9h, six bits, two top bits read zero.
`ifndef ALARM_COMPARE_MAP_VH
`define ALARM_COMPARE_MAP_VH
`define ADDR_WEEKLY_ALARM_MINUTE 4'h8
`define ADDR_WEEKLY_ALARM_HOUR 4'h9
`define ADDR_WEEKLY_ALARM_WEEKDAY_MASK 4'ha
`define ADDR_DAILY_ALARM_MINUTE 4'hb
`define ADDR_DAILY_ALARM_HOUR 4'hc
`define ADDR_ALARM_STATUS 4'hd
`define ADDR_ALARM_MASK 4'he
`define MINUTE_BITS 7
`define HOUR_BITS 6
`define WEEKDAY_BITS 7
`define STAT_WEEKLY 0
`define STAT_DAILY 1
`define STAT_BITS 2
`define ALARM_FIELD_RESET 8'h00
`endif

// File: core/alarm_compare_registers.v
// Alarm setting registers, alarm comparison and alarm interrupt status.
`timescale 1ns/1ps
`include "alarm_compare_map.vh"
module alarm_compare_registers #(
  parameter MINUTE_W = `MINUTE_BITS,
  parameter HOUR_W = `HOUR_BITS,
  parameter DAYS = `WEEKDAY_BITS
) (
  input wire ref_clk,
  input wire sys_rst,
  input wire clk_en,
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  input wire [6:0] time_minute,
  input wire [5:0] time_hour,
  input wire [2:0] weekday_counter,
  input wire minute_tick,
  input wire osc_stop_flag,
  output reg weekly_alarm_event,
  output reg daily_alarm_event,
  output reg alarm_irq
);

  // Stored alarm fields; the fixed-zero bits above each field are not kept.
  reg [MINUTE_W-1:0] weekly_alarm_minute;
  reg [HOUR_W-1:0] weekly_alarm_hour;
  reg [DAYS-1:0] weekly_alarm_weekday_mask;
  reg [MINUTE_W-1:0] daily_alarm_minute;
  reg [HOUR_W-1:0] daily_alarm_hour;
  reg [`STAT_BITS-1:0] alarm_status;
  reg [`STAT_BITS-1:0] alarm_mask;

  reg [MINUTE_W-1:0] next_weekly_minute;
  reg [HOUR_W-1:0] next_weekly_hour;
  reg [DAYS-1:0] next_weekday_mask;
  reg [MINUTE_W-1:0] next_daily_minute;
  reg [HOUR_W-1:0] next_daily_hour;
  reg [`STAT_BITS-1:0] next_mask;
  reg [7:0] next_rdata;
  wire [`STAT_BITS-1:0] next_status;
  wire next_irq;

  reg wr_weekly_minute;
  reg wr_weekly_hour;
  reg wr_weekday_mask;
  reg wr_daily_minute;
  reg wr_daily_hour;
  reg wr_status;
  reg wr_mask;
  wire field_lock;

  wire [7:0] word_weekly_minute;
  wire [7:0] word_weekly_hour;
  wire [7:0] word_weekday_mask;
  wire [7:0] word_daily_minute;
  wire [7:0] word_daily_hour;
  wire [7:0] word_status;
  wire [7:0] word_mask;

  wire weekly_alarm_hour_tens20;
  wire daily_alarm_hour_tens20;
  wire time_hour_tens20;
  wire weekly_minute_eq;
  wire weekly_hour_low_eq;
  wire weekly_hour_top_eq;
  wire daily_minute_eq;
  wire daily_hour_low_eq;
  wire daily_hour_top_eq;
  wire weekday_valid;
  wire [DAYS-1:0] day_hit;
  wire day_enabled;
  wire weekly_match;
  wire daily_match;
  wire [`STAT_BITS-1:0] hit;
  wire [`STAT_BITS-1:0] clear;
  genvar i;
  genvar j;

  // Every register write is decoded once here and shared by the fields below.
  always @* begin
    wr_weekly_minute = 1'b0;
    wr_weekly_hour = 1'b0;
    wr_weekday_mask = 1'b0;
    wr_daily_minute = 1'b0;
    wr_daily_hour = 1'b0;
    wr_status = 1'b0;
    wr_mask = 1'b0;
    if (reg_wr) begin
      case (reg_addr)
        `ADDR_WEEKLY_ALARM_MINUTE: begin
          wr_weekly_minute = 1'b1;
        end
        `ADDR_WEEKLY_ALARM_HOUR: begin
          wr_weekly_hour = 1'b1;
        end
        `ADDR_WEEKLY_ALARM_WEEKDAY_MASK: begin
          wr_weekday_mask = 1'b1;
        end
        `ADDR_DAILY_ALARM_MINUTE: begin
          wr_daily_minute = 1'b1;
        end
        `ADDR_DAILY_ALARM_HOUR: begin
          wr_daily_hour = 1'b1;
        end
        `ADDR_ALARM_STATUS: begin
          wr_status = 1'b1;
        end
        `ADDR_ALARM_MASK: begin
          wr_mask = 1'b1;
        end
        default: begin
        end
      endcase
    end
  end

  assign field_lock = osc_stop_flag;

  // While the oscillator stop condition stands the fields are held at zero and
  // writes are ignored; the hardware leaves them undefined, and zero is the one
  // value that keeps the weekly alarm silent until software programs it again.
  always @* begin
    next_weekly_minute = weekly_alarm_minute;
    if (field_lock) begin
      next_weekly_minute = {MINUTE_W{1'b0}};
    end else if (wr_weekly_minute) begin
      next_weekly_minute = reg_wdata[MINUTE_W-1:0];
    end
  end

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      weekly_alarm_minute <= {MINUTE_W{1'b0}};
    end else if (clk_en) begin
      weekly_alarm_minute <= next_weekly_minute;
    end
  end

  always @* begin
    next_weekly_hour = weekly_alarm_hour;
    if (field_lock) begin
      next_weekly_hour = {HOUR_W{1'b0}};
    end else if (wr_weekly_hour) begin
      next_weekly_hour = reg_wdata[HOUR_W-1:0];
    end
  end

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      weekly_alarm_hour <= {HOUR_W{1'b0}};
    end else if (clk_en) begin
      weekly_alarm_hour <= next_weekly_hour;
    end
  end

  always @* begin
    next_weekday_mask = weekly_alarm_weekday_mask;
    if (field_lock) begin
      next_weekday_mask = {DAYS{1'b0}};
    end else if (wr_weekday_mask) begin
      next_weekday_mask = reg_wdata[DAYS-1:0];
    end
  end

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      weekly_alarm_weekday_mask <= {DAYS{1'b0}};
    end else if (clk_en) begin
      weekly_alarm_weekday_mask <= next_weekday_mask;
    end
  end

  always @* begin
    next_daily_minute = daily_alarm_minute;
    if (field_lock) begin
      next_daily_minute = {MINUTE_W{1'b0}};
    end else if (wr_daily_minute) begin
      next_daily_minute = reg_wdata[MINUTE_W-1:0];
    end
  end

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      daily_alarm_minute <= {MINUTE_W{1'b0}};
    end else if (clk_en) begin
      daily_alarm_minute <= next_daily_minute;
    end
  end

  always @* begin
    next_daily_hour = daily_alarm_hour;
    if (field_lock) begin
      next_daily_hour = {HOUR_W{1'b0}};
    end else if (wr_daily_hour) begin
      next_daily_hour = reg_wdata[HOUR_W-1:0];
    end
  end

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      daily_alarm_hour <= {HOUR_W{1'b0}};
    end else if (clk_en) begin
      daily_alarm_hour <= next_daily_hour;
    end
  end

  always @* begin
    next_mask = alarm_mask;
    if (wr_mask) begin
      next_mask = reg_wdata[`STAT_BITS-1:0];
    end
  end

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      alarm_mask <= {`STAT_BITS{1'b0}};
    end else if (clk_en) begin
      alarm_mask <= next_mask;
    end
  end

  // One decode per weekday; the value seven selects no bit and never matches.
  assign weekday_valid = (weekday_counter != 3'h7);
  generate
    for (i = 0; i < DAYS; i = i + 1) begin : g_day
      assign day_hit[i] = weekly_alarm_weekday_mask[i] && weekday_valid && (weekday_counter == i);
    end
  endgenerate
  assign day_enabled = |day_hit;

  // Hours are compared as raw six-bit codes: bit five is the p.m. flag in the
  // 12-hour format and the tens-twenty bit in the 24-hour format, and either
  // way it must equal the counter's bit five, so midnight 12 and noon 32 work.
  assign weekly_alarm_hour_tens20 = weekly_alarm_hour[HOUR_W-1];
  assign daily_alarm_hour_tens20 = daily_alarm_hour[HOUR_W-1];
  assign time_hour_tens20 = time_hour[HOUR_W-1];
  assign weekly_minute_eq = (time_minute == weekly_alarm_minute);
  assign weekly_hour_low_eq = (time_hour[HOUR_W-2:0] == weekly_alarm_hour[HOUR_W-2:0]);
  assign weekly_hour_top_eq = (time_hour_tens20 == weekly_alarm_hour_tens20);
  assign daily_minute_eq = (time_minute == daily_alarm_minute);
  assign daily_hour_low_eq = (time_hour[HOUR_W-2:0] == daily_alarm_hour[HOUR_W-2:0]);
  assign daily_hour_top_eq = (time_hour_tens20 == daily_alarm_hour_tens20);
  assign weekly_match = weekly_minute_eq && weekly_hour_low_eq && weekly_hour_top_eq &&
    day_enabled;
  assign daily_match = daily_minute_eq && daily_hour_low_eq && daily_hour_top_eq;
  // A match counts only on the tick that opens a new minute, so an alarm
  // time that stands for a whole minute raises its event once.
  assign hit[`STAT_WEEKLY] = minute_tick && weekly_match;
  assign hit[`STAT_DAILY] = minute_tick && daily_match;

  // Status bits are cleared by writing ones; an event in the same cycle wins.
  assign clear = wr_status ? reg_wdata[`STAT_BITS-1:0] : {`STAT_BITS{1'b0}};
  generate
    for (j = 0; j < `STAT_BITS; j = j + 1) begin : g_status
      assign next_status[j] = hit[j] | (alarm_status[j] & ~clear[j]);
    end
  endgenerate

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      alarm_status <= {`STAT_BITS{1'b0}};
    end else if (clk_en) begin
      alarm_status <= next_status;
    end
  end

  // Read words with their fixed-zero bits in place.
  assign word_weekly_minute = {{(8-MINUTE_W){1'b0}}, weekly_alarm_minute};
  assign word_weekly_hour = {{(8-HOUR_W){1'b0}}, weekly_alarm_hour};
  assign word_weekday_mask = {{(8-DAYS){1'b0}}, weekly_alarm_weekday_mask};
  assign word_daily_minute = {{(8-MINUTE_W){1'b0}}, daily_alarm_minute};
  assign word_daily_hour = {{(8-HOUR_W){1'b0}}, daily_alarm_hour};
  assign word_status = {{(8-`STAT_BITS){1'b0}}, alarm_status};
  assign word_mask = {{(8-`STAT_BITS){1'b0}}, alarm_mask};

  always @* begin
    case (reg_addr)
      `ADDR_WEEKLY_ALARM_MINUTE: begin
        next_rdata = word_weekly_minute;
      end
      `ADDR_WEEKLY_ALARM_HOUR: begin
        next_rdata = word_weekly_hour;
      end
      `ADDR_WEEKLY_ALARM_WEEKDAY_MASK: begin
        next_rdata = word_weekday_mask;
      end
      `ADDR_DAILY_ALARM_MINUTE: begin
        next_rdata = word_daily_minute;
      end
      `ADDR_DAILY_ALARM_HOUR: begin
        next_rdata = word_daily_hour;
      end
      `ADDR_ALARM_STATUS: begin
        next_rdata = word_status;
      end
      `ADDR_ALARM_MASK: begin
        next_rdata = word_mask;
      end
      default: begin
        next_rdata = 8'h00;
      end
    endcase
  end

  // Read data stand until the next enabled cycle without a read, then fall back to zero.
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (clk_en) begin
      if (reg_rd) begin
        reg_rdata <= next_rdata;
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      weekly_alarm_event <= 1'b0;
    end else if (clk_en) begin
      weekly_alarm_event <= hit[`STAT_WEEKLY];
    end
  end

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      daily_alarm_event <= 1'b0;
    end else if (clk_en) begin
      daily_alarm_event <= hit[`STAT_DAILY];
    end
  end

  // The interrupt looks at the next status so that it rises with the event.
  assign next_irq = |(next_status & alarm_mask);

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      alarm_irq <= 1'b0;
    end else if (clk_en) begin
      alarm_irq <= next_irq;
    end
  end

endmodule // alarm_compare_registers

// File: test/alarm_checker.sv
// Port checker for the alarm compare block.
`timescale 1ns/1ps
module alarm_checker (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic reg_rd,
  input wire logic minute_tick,
  input wire logic osc_stop_flag,
  input wire logic weekly_alarm_event,
  input wire logic daily_alarm_event,
  input wire logic alarm_irq,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_rdata,
  input wire logic [2:0] weekday_counter
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  sequence rd_s(a); clk_en && reg_rd && reg_addr == a; endsequence
  sequence day7_s; clk_en && minute_tick && weekday_counter == 3'h7; endsequence
  chk_min_top: assert property (rd_s(4'hb) |=> !reg_rdata[7]) else $error("minute d7");
  chk_hour_top: assert property (rd_s(4'hc) |=> !reg_rdata[7:6]) else $error("hour d7");
  chk_mask_top: assert property (rd_s(4'ha) |=> !reg_rdata[7]) else $error("mask d7");
  chk_osc_zero: assert property ($past(osc_stop_flag) && osc_stop_flag ##0 rd_s(4'hb)
    |=> reg_rdata == 8'h00) else $error("osc stop field");
  chk_day_seven: assert property (day7_s |=> !weekly_alarm_event) else $error("day 7");
  chk_week_cause: assert property (weekly_alarm_event |-> $past(minute_tick)) else $error("wk");
  chk_daily_cause: assert property (daily_alarm_event |-> $past(minute_tick)) else $error("dy");
  chk_read_idle: assert property (clk_en && !reg_rd |=> !reg_rdata) else $error("rdata");
  chk_freeze_hold: assert property (!clk_en |=> $stable(reg_rdata) && $stable(alarm_irq) &&
    $stable(daily_alarm_event) && $stable(weekly_alarm_event)) else $error("frozen output moved");
endmodule // alarm_checker
bind alarm_compare_registers alarm_checker i_alarm_checker (
  .ref_clk(ref_clk),
  .sys_rst(sys_rst),
  .clk_en(clk_en),
  .reg_rd(reg_rd),
  .minute_tick(minute_tick),
  .osc_stop_flag(osc_stop_flag),
  .weekly_alarm_event(weekly_alarm_event),
  .daily_alarm_event(daily_alarm_event),
  .alarm_irq(alarm_irq),
  .reg_addr(reg_addr),
  .reg_rdata(reg_rdata),
  .weekday_counter(weekday_counter)
);

// File: test/host_bus.sv
// Host bus master model for the alarm register port.
`timescale 1ns/1ps
module host_bus (
  input wire logic ref_clk,
  input wire logic [7:0] reg_rdata,
  output logic [3:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd
);
  initial {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
  // Callers pass raw register bytes, some with fixed-zero bits set, to any address.
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge ref_clk) reg_wr <= 0;
  endtask
  task rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge ref_clk) {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge ref_clk) reg_rd <= 0;
    #1 d = reg_rdata;
  endtask
endmodule // host_bus

// File: test/tb_top.sv
// Self-checking bench for the alarm compare block.
`timescale 1ns/1ps
module tb_top;
  logic ref_clk = 0, sys_rst = 1, clk_en = 1, minute_tick = 0, osc_stop_flag = 0;
  logic reg_wr, reg_rd;
  logic weekly_alarm_event, daily_alarm_event, alarm_irq;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, v;
  logic [6:0] time_minute = 0;
  logic [5:0] time_hour = 0;
  logic [2:0] weekday_counter = 0;
  logic [11:0] cfg [6] = '{12'h830, 12'h932, 12'ha08, 12'hb30, 12'hc32, 12'he03};
  logic [7:0] fld_in [5] = '{8'hd9, 8'hd2, 8'hff, 8'hd9, 8'hd2};
  logic [7:0] fld_out [5] = '{8'h59, 8'h12, 8'h7f, 8'h59, 8'h12};
  int bad_count = 0, checks = 0;
  initial forever #50 ref_clk = ~ref_clk;
  host_bus i_host_bus (
    .ref_clk(ref_clk),
    .reg_rdata(reg_rdata),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd)
  );
  alarm_compare_registers i_alarm_compare_registers (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .time_minute(time_minute),
    .time_hour(time_hour),
    .weekday_counter(weekday_counter),
    .minute_tick(minute_tick),
    .osc_stop_flag(osc_stop_flag),
    .weekly_alarm_event(weekly_alarm_event),
    .daily_alarm_event(daily_alarm_event),
    .alarm_irq(alarm_irq)
  );
  task cmp(input string n, input logic [7:0] e, g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task chk_reg(input logic [3:0] a, input logic [7:0] e);
    i_host_bus.rd(a, v);
    cmp("register", e, v);
  endtask
  task tk(input logic [2:0] d, input logic [1:0] e);
    @(posedge ref_clk) {time_minute, time_hour, weekday_counter, minute_tick} <= {7'h30, 6'h32, d, 1'b1};
    @(posedge ref_clk) minute_tick <= 0;
    #1 cmp("events", {6'h0, e}, {6'h0, weekly_alarm_event, daily_alarm_event});
  endtask
  task t_fields;
    for (int i = 0; i < 5; i++) begin
      i_host_bus.wr(4'h8 + i[3:0], fld_in[i]);
      chk_reg(4'h8 + i[3:0], fld_out[i]);
    end
    i_host_bus.wr(4'h3, 8'hff);
    chk_reg(4'h3, 8'h00);
  endtask
  task t_alarm;
    foreach (cfg[k]) i_host_bus.wr(cfg[k][11:8], cfg[k][7:0]);
    tk(3'h3, 2'b11);
    cmp("irq", 8'h01, {7'h0, alarm_irq});
    tk(3'h2, 2'b01);
    chk_reg(4'hd, 8'h03);
    i_host_bus.wr(4'hd, 8'h03);
    chk_reg(4'hd, 8'h00);
    cmp("irq", 8'h00, {7'h0, alarm_irq});
    i_host_bus.wr(4'ha, 8'h00);
    tk(3'h3, 2'b01);
    tk(3'h7, 2'b01);
  endtask
  task t_freeze;
    @(posedge ref_clk) clk_en <= 0;
    i_host_bus.wr(4'hb, 8'h45);
    tk(3'h3, 2'b00);
    @(posedge ref_clk) clk_en <= 1;
    chk_reg(4'hb, 8'h30);
  endtask
  task t_osc;
    @(posedge ref_clk) osc_stop_flag <= 1;
    i_host_bus.wr(4'hb, 8'h12);
    chk_reg(4'hb, 8'h00);
    @(posedge ref_clk) osc_stop_flag <= 0;
  endtask
  task complete_run;
    if (bad_count == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    sys_rst <= 0;
    t_fields;
    t_alarm;
    t_freeze;
    t_osc;
    complete_run;
  end
  // The whole sequence needs about 70 cycles, so 1000 cycles means a hang.
  initial begin
    #100000 bad_count++;
    complete_run;
  end
endmodule // tb_top
